//--- test/flash_entry_properties.sv
`timescale 1ns/10ps
module flash_entry_properties (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic POR_ACTIVE,
  input wire logic SCK,
  input wire logic CHIP_SELECT_N,
  input wire logic SO_OE,
  input wire logic MODE3,
  input wire logic READ_OK,
  input wire logic WRITE_OK,
  input wire logic STANDBY,
  input wire logic ACTIVE,
  input wire logic CMD_VALID,
  input wire logic CMD_REJECTED
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // Gating of output, commands and states
  oe_quiet_a: assert property (!READ_OK |-> !SO_OE) else $error("output early");
  por_quiet_a: assert property (POR_ACTIVE [*5] |-> !(CMD_VALID || CMD_REJECTED))
    else $error("command in power reset");
  write_gate_a: assert property (!WRITE_OK |-> !STANDBY && !ACTIVE)
    else $error("state before delay");
  idle_pick_a: assert property ((WRITE_OK && CHIP_SELECT_N) [*4] |-> STANDBY)
    else $error("no standby");
  busy_pick_a: assert property ((WRITE_OK && !CHIP_SELECT_N) [*4] |-> ACTIVE)
    else $error("no active");
  reject_gate_a: assert property (CMD_REJECTED |-> !($past(READ_OK) && $past(WRITE_OK)))
    else $error("late reject");
  // Mode pick from clock level at select fall
  mode_three_a: assert property (($fell(CHIP_SELECT_N) && SCK && READ_OK)
    ##1 (SCK && !CHIP_SELECT_N) [*3] |=> MODE3) else $error("mode 3 missed");
  mode_zero_a: assert property (($fell(CHIP_SELECT_N) && !SCK && READ_OK)
    ##1 (!SCK && !CHIP_SELECT_N) [*3] |=> !MODE3) else $error("mode 0 missed");
  cover property (CMD_VALID && MODE3);
  cover property (CMD_REJECTED);
  cover property (STANDBY);
  cover property (CMD_VALID && !MODE3);
endmodule

//--- test/serial_flash_powerup_and_addressing_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value t=%0t mismatch", $time); end end
module serial_flash_powerup_and_addressing_test;
  import flash_entry_pkg::*;
  logic CLK_SYS = 0, RESET = 1, POR_ACTIVE = 1, m3;
  wire SCK, SI, CHIP_SELECT_N;
  logic SO, SO_OE, MODE3, READ_OK, WRITE_OK, STANDBY, ACTIVE, CMD_VALID, CMD_REJECTED;
  logic [OPC_BITS-1:0] CMD_OPCODE;
  logic [PAGE_BITS-1:0] PAGE_ADDR;
  logic [BYTE_BITS-1:0] BYTE_ADDR;
  logic [31:0] f;
  logic [7:0] ops [6] = '{8'h0B, 8'h1B, 8'hD2, 8'h82, 8'h85, 8'hD7};
  int fail_count = 0, check_count = 0;
  integer nv = 0, nr = 0, oe_cycles = 0;
  flash_entry #(.READ_WAIT(400), .WRITE_WAIT(1200)) u_dut (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .POR_ACTIVE(POR_ACTIVE), .SCK(SCK), .SI(SI),
    .CHIP_SELECT_N(CHIP_SELECT_N), .SO(SO), .SO_OE(SO_OE), .MODE3(MODE3),
    .READ_OK(READ_OK), .WRITE_OK(WRITE_OK), .STANDBY(STANDBY), .ACTIVE(ACTIVE),
    .CMD_VALID(CMD_VALID), .CMD_OPCODE(CMD_OPCODE), .PAGE_ADDR(PAGE_ADDR),
    .BYTE_ADDR(BYTE_ADDR), .CMD_REJECTED(CMD_REJECTED));
  spi_host_model u_host (.clk(CLK_SYS), .sck(SCK), .si(SI), .cs_n(CHIP_SELECT_N));
  initial forever #10 CLK_SYS = ~CLK_SYS;
  // Count answer pulses
  always @(negedge CLK_SYS)
  begin
    nv += CMD_VALID;
    nr += CMD_REJECTED;
    oe_cycles += SO_OE;
  end
  // Program/erase class of an opcode
  function automatic bit prog_op(input logic [7:0] op);
    return op[7] && (op[7:4] != 4'hD);
  endfunction
  task complete_run();
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Send a frame and check the answer
  task frame(input logic [31:0] fr, input logic md, input int ev, input int er);
    nv = 0;
    nr = 0;
    oe_cycles = 0;
    u_host.send(fr, md);
    `CHK(nv, ev)
    `CHK(nr, er)
    `CHK(oe_cycles > 0, (ev == 1) && !prog_op(fr[31:24]))
    $display("frame %h done", fr);
  endtask
  initial
  begin
    void'($urandom(32'hB5FE));
    repeat (5) @(negedge CLK_SYS);
    RESET = 0;
    `CHK(SO_OE, 1'b0)
    frame(32'h0B000000, 1'b0, 0, 0);
    @(negedge CLK_SYS) POR_ACTIVE = 0;
    frame(32'h0BFFFFFF, 1'b1, 0, 1);
    frame(32'h82000000, 1'b0, 0, 1);
    frame(32'hD2ABCDEF, 1'b1, 1, 0);
    `CHK({STANDBY, ACTIVE}, 2'h0)
    for (int n = 0; n < 2000 && WRITE_OK !== 1'b1; n++) @(negedge CLK_SYS);
    `CHK(WRITE_OK, 1'b1)
    if (WRITE_OK !== 1'b1) complete_run();
    `CHK(STANDBY, 1'b1)
    repeat (12)
    begin
      f = $urandom;
      f[31:24] = ops[$urandom % 6];
      m3 = 1'($urandom);
      frame(f, m3, 1, 0);
      `CHK(MODE3, m3)
      `CHK(SO, m3 ? f[1] : f[0])
      `CHK({CMD_OPCODE, PAGE_ADDR, BYTE_ADDR}, {f[31:24], f[19:0]})
    end
    // Power reset in mid-run clears both waits and ignores a frame
    @(negedge CLK_SYS) POR_ACTIVE = 1;
    frame($urandom, 1'b0, 0, 0);
    `CHK(READ_OK, 1'b0)
    `CHK(WRITE_OK, 1'b0)
    `CHK({STANDBY, ACTIVE}, 2'h0)
    @(negedge CLK_SYS) POR_ACTIVE = 0;
    frame(32'h85000000, 1'b0, 0, 1);
    complete_run();
  end
endmodule
bind flash_entry flash_entry_properties u_props (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .POR_ACTIVE(POR_ACTIVE), .SCK(SCK),
  .CHIP_SELECT_N(CHIP_SELECT_N), .SO_OE(SO_OE), .MODE3(MODE3), .READ_OK(READ_OK),
  .WRITE_OK(WRITE_OK), .STANDBY(STANDBY), .ACTIVE(ACTIVE), .CMD_VALID(CMD_VALID),
  .CMD_REJECTED(CMD_REJECTED));

//--- test/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
  input wire logic clk,
  output logic sck,
  output logic si,
  output logic cs_n
);
  initial {sck, si, cs_n} = 3'h1;
  // Half of the link clock period
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  // One whole frame, clock still outside it
  task automatic send(input logic [31:0] fr, input logic md);
    sck = md;
    half();
    cs_n = 1'b0;
    // Select setup, clock still at its idle level
    half();
    for (int i = 31; i >= 0; i--)
    begin
      sck = 1'b0;
      si = fr[i];
      half();
      sck = 1'b1;
      half();
    end
    sck = md;
    half();
    cs_n = 1'b1;
    si = ~si; // Released line shows no stale value
    half();
  endtask
endmodule

//--- verilog/flash_entry.sv
// How it works
// RULE1 - Data output stays undriven after reset until a command selects it.
// RULE2 - No command is taken until chip select falls after reset.
// RULE3 - Clock level at each chip select fall outside power reset picks mode 0 or 3.
// RULE4 - While power-on reset is held, every command is ignored.
// RULE5 - Host waits 70 us before a read; flag shows when reads are safe.
// RULE6 - Program or erase is held off until the 3 ms delay passes.
// RULE7 - After the delay, enter standby if select high, else active.
// RULE8 - Address: 4 reserved, 11 page bits, 9 byte bits, MSB first.
`timescale 1ns/10ps
module flash_entry
  import flash_entry_pkg::*;
#(
  parameter int READ_WAIT = READ_WAIT_CYC,
  parameter int WRITE_WAIT = WRITE_WAIT_CYC
)(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic POR_ACTIVE,
  input wire logic SCK,
  input wire logic SI,
  input wire logic CHIP_SELECT_N,
  output logic SO,
  output logic SO_OE,
  output logic MODE3,
  output logic READ_OK,
  output logic WRITE_OK,
  output logic STANDBY,
  output logic ACTIVE,
  output logic CMD_VALID,
  output logic [OPC_BITS-1:0] CMD_OPCODE,
  output logic [PAGE_BITS-1:0] PAGE_ADDR,
  output logic [BYTE_BITS-1:0] BYTE_ADDR,
  output logic CMD_REJECTED
);
  // Synchroniser stages, one pair per pin
  logic [1:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] si_s;
  logic [1:0] por_s;

  // Previous synchronised levels for edge finding
  logic sck_d;
  logic cs_d;

  // Frame capture state
  logic armed;
  logic [5:0] bit_cnt;
  logic [31:0] shift;

  // Power-up sequencing state
  logic [22:0] timer;
  pwr_state_t state;

  // Program/erase class: bit 7 set, but not the status or 0xDx read family
  function automatic logic prog_class(input logic [OPC_BITS-1:0] code);
    prog_class = code[7] & (code != OPC_STATUS) & (code[7:4] != 4'hD);
  endfunction

  // Settled pin levels, taken from the second stage only
  wire sck_now = sck_s[1];
  wire cs_now = cs_s[1];
  wire si_now = si_s[1];
  wire por_now = por_s[1];

  // Select edges
  wire cs_fall = cs_d & ~cs_now;
  wire cs_rise = ~cs_d & cs_now;

  // Sampling edge: rising in both mode 0 and mode 3
  wire sck_rise = ~sck_d & sck_now & ~cs_now;
  // Output edge: data out moves on the falling edge
  wire sck_fall = sck_d & ~sck_now & ~cs_now;

  // Shift path and end of the 32nd bit
  wire [31:0] next_shift = {shift[30:0], si_now};
  wire frame_done = sck_rise & armed & (bit_cnt == 6'(OPC_BITS + ADDR_BITS - 1));
  wire [OPC_BITS-1:0] opc = next_shift[31:24];

  // Opcode gating by the power-up waits
  wire is_write = prog_class(opc);
  wire is_read = ~is_write;
  wire allowed = is_read ? READ_OK : WRITE_OK;

  // Any state but power reset takes commands
  wire powered = (state != PWR_RESET);

  // Two-flop synchronisers for every pin
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      // Pins read as idle during reset, power-on reset as held
      sck_s <= 2'h0;
      cs_s <= 2'h3;
      si_s <= 2'h0;
      por_s <= 2'h3;
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      // Every pin moves one stage per clock
      sck_s <= {sck_s[0], SCK};
      cs_s <= {cs_s[0], CHIP_SELECT_N};
      si_s <= {si_s[0], SI};
      por_s <= {por_s[0], POR_ACTIVE};
      sck_d <= sck_now;
      cs_d <= cs_now;
    end
  end

  // Power-up sequencing and wait timer
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      state <= PWR_RESET;
      timer <= 23'h0;
      READ_OK <= 1'b0;
      WRITE_OK <= 1'b0;
    end
    else if (por_now)
    begin
      state <= PWR_RESET; // RULE4
      timer <= 23'h0;
      READ_OK <= 1'b0;
      WRITE_OK <= 1'b0;
    end
    else
    begin
      // Saturating count from POR release
      if (timer != 23'h7FFFFF)
        timer <= timer + 23'h1;
      if (timer >= 23'(READ_WAIT))
        READ_OK <= 1'b1; // RULE5
      // Wait out the write delay, then follow select
      case (state)
        PWR_RESET: state <= PWR_WAIT;
        PWR_WAIT:
        begin
          if (timer >= 23'(WRITE_WAIT))
          begin
            WRITE_OK <= 1'b1; // RULE6
            state <= cs_now ? PWR_STANDBY : PWR_ACTIVE; // RULE7
          end
        end
        PWR_STANDBY: if (!cs_now) state <= PWR_ACTIVE;
        PWR_ACTIVE: if (cs_now) state <= PWR_STANDBY;
        default: state <= PWR_RESET;
      endcase
    end
  end

  // Decode of the two visible power states
  assign STANDBY = (state == PWR_STANDBY);
  assign ACTIVE = (state == PWR_ACTIVE);

  // Frame capture: opcode then 24 address bits
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      armed <= 1'b0;
      bit_cnt <= 6'h0;
      shift <= 32'h0;
      MODE3 <= 1'b0;
      CMD_VALID <= 1'b0;
      CMD_REJECTED <= 1'b0;
      CMD_OPCODE <= 8'h00;
      PAGE_ADDR <= 11'h000;
      BYTE_ADDR <= 9'h000;
    end
    else
    begin
      CMD_VALID <= 1'b0;
      CMD_REJECTED <= 1'b0;
      // Select fall arms a frame and latches the mode
      if (cs_fall & powered)
      begin
        armed <= 1'b1; // RULE2
        bit_cnt <= 6'h0;
        MODE3 <= sck_now; // RULE3
      end
      else if (cs_rise | ~powered)
        armed <= 1'b0; // RULE4
      else if (sck_rise & armed)
      begin
        shift <= next_shift;
        bit_cnt <= bit_cnt + 6'h1;
        // Hand over the fields once all 32 bits are in
        if (frame_done)
        begin
          armed <= 1'b0;
          CMD_OPCODE <= opc;
          PAGE_ADDR <= next_shift[PAGE_ADDR_MSB -: PAGE_BITS]; // RULE8
          BYTE_ADDR <= next_shift[BYTE_ADDR_MSB -: BYTE_BITS]; // RULE8
          CMD_VALID <= allowed; // RULE6
          CMD_REJECTED <= ~allowed;
        end
      end
    end
  end

  // Output stays off until an accepted read command selects the device
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      SO_OE <= 1'b0;
      SO <= 1'b0;
    end
    // Release the line whenever select is high
    else if (cs_now | ~powered)
      SO_OE <= 1'b0; // RULE1
    else
    begin
      // Drive only for an accepted read
      if (frame_done & allowed & is_read)
        SO_OE <= 1'b1; // RULE1
      if (sck_fall)
        SO <= shift[0];
    end
  end
endmodule

//--- verilog/flash_entry_pkg.sv
package flash_entry_pkg;
  // Power-up timing
  localparam int CLK_HZ = 50000000;
  localparam int READ_WAIT_US = 70;
  localparam int WRITE_WAIT_MS = 3;
  localparam int READ_WAIT_CYC = (READ_WAIT_US * (CLK_HZ / 1000000));
  localparam int WRITE_WAIT_CYC = (WRITE_WAIT_MS * (CLK_HZ / 1000));
  // Address field layout (24 bits after the opcode)
  localparam int ADDR_BITS = 24;
  localparam int PAGE_BITS = 11;
  localparam int BYTE_BITS = 9;
  localparam int PAGE_ADDR_MSB = 19;
  localparam int BYTE_ADDR_MSB = 8;
  localparam int OPC_BITS = 8;
  // Status read opcode, kept out of the program/erase class
  localparam logic [7:0] OPC_STATUS = 8'hD7;
  typedef enum logic [1:0] {PWR_RESET, PWR_WAIT, PWR_STANDBY, PWR_ACTIVE} pwr_state_t;
endpackage
